// ===== hw/jtm_core.sv
// Command-driven master for a 1149.1 test access port, 8-bit host bus
// Host pins and TDI are asynchronous and pass two flip-flops first
`timescale 1ns/1ns
`include "jtm_regs.svh"
module jtm_core
    import jtm_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input jtm_host_t host,
    output logic [7:0] host_dout,
    output logic host_doe,
    output logic rdy,
    input wire logic tdi,
    output jtm_tap_pins_t tap_pins
);
    jtm_core_t r, n;
    jtm_op_t op, nop;
    jtm_tap_t end_st, step_goal, step_nxt;
    logic step_toward;
    logic acc, rd, busy, disc, gated, blocked, run, tick, rise, fall;
    logic eff_work, at_work, bit_ok, stall_hi;
    logic [2:0] a;
    logic [7:0] wd, half;
    logic oq_push, oq_pop, oq_full, oq_empty;
    logic iq_push, iq_pop, iq_full, iq_empty;
    logic [7:0] oq_rdata, iq_wdata, iq_rdata;
    logic flush, software_full_reset_bit;

    function automatic jtm_op_t op_dec(input logic [3:0] c);
        jtm_op_t o;
        o = '0;
        o.addressed_scan_port = c inside {4'h3, 4'h4, 4'h5};
        o.scan = c[3] || o.addressed_scan_port;
        o.uses_in = c == 4'h3 || c == 4'h4 || (c[3] && c[2:1] != 2'h2);
        o.uses_out = c == 4'h4 || c == 4'h5 || (c[3] && !c[1]);
        o.recirc = c[3] && c[2] && c[1];
        o.work = !c[3] ? TAP_RTI : (c[0] ? TAP_SHDR : TAP_SHIR);
        return o;
    endfunction

    function automatic jtm_tap_t end_dec(input logic [1:0] e);
        unique case (e)
            2'h0: return TAP_TLR;
            2'h1: return TAP_RTI;
            2'h2: return TAP_PAUSEDR;
            2'h3: return TAP_PAUSEIR;
        endcase
    endfunction

    function automatic jtm_core_t rst_val();
        jtm_core_t v;
        v = '0;
        v.host_s1.strb_n = 1'h1;
        v.host_s2.strb_n = 1'h1;
        v.cfga = `JTM_CFGA_RST;
        v.cfgb = `JTM_CFGB_RST;
        v.pin = `JTM_PIN_RST;
        v.fsm = FSM_IDLE;
        v.tap = TAP_TLR;
        v.goal = TAP_TLR;
        v.tms = 1'h1;
        v.tdo = 1'h1;
        v.po.tms = 1'h1;
        v.po.tdo = 1'h1;
        v.po.trst_n = 1'h1;
        return v;
    endfunction

    jtm_fifo u_outq (
        .clock(clock),
        .nrst(nrst),
        .ce(ce),
        .flush(flush),
        .push(oq_push),
        .wdata(wd),
        .pop(oq_pop),
        .rdata(oq_rdata),
        .full(oq_full),
        .empty(oq_empty)
    );

    jtm_fifo u_inq (
        .clock(clock),
        .nrst(nrst),
        .ce(ce),
        .flush(flush),
        .push(iq_push),
        .wdata(iq_wdata),
        .pop(iq_pop),
        .rdata(iq_rdata),
        .full(iq_full),
        .empty(iq_empty)
    );

    jtm_tap_step u_step (
        .cur(r.tap),
        .goal(step_goal),
        .tms(r.tms),
        .toward(step_toward),
        .nxt(step_nxt)
    );

    assign op = op_dec(r.cmd[3:0]);
    assign nop = op_dec(wd[3:0]);
    assign end_st = end_dec(r.cmd[5:4]);
    assign busy = r.fsm != FSM_IDLE;
    assign disc = r.cfga[2:0] == `JTM_MODE_DISCRETE;
    assign gated = r.cfgb[`JTM_CFGB_GATED];
    assign a = r.host_s2.addr;
    assign rd = r.host_s2.rw;
    assign wd = r.host_s2.data;
    assign acc = !r.host_s2.strb_n && !r.acc_done;
    assign blocked = rd ? (a == `JTM_A_INQ && iq_empty)
        : ((a == `JTM_A_OUTQ && oq_full)
        || (a == `JTM_A_CMD && busy && !wd[`JTM_CMD_SOFTWARE_FULL_RESET_BIT]));
    assign rdy = !(acc && blocked);
    assign eff_work = r.fsm == FSM_WORK
        || (r.fsm == FSM_SEEK && r.tap == r.goal);
    assign at_work = eff_work && (op.addressed_scan_port || r.tap == r.goal);
    assign bit_ok = (!op.uses_out || r.out_cnt != 4'h0)
        && (!op.uses_in || r.in_cnt != 4'h8);
    // Buffer stalls freeze TCK high, before the bit that cannot move
    assign stall_hi = at_work && op.scan && r.tck && !bit_ok;
    assign run = !disc && (busy ? !stall_hi : (!gated || r.tck));
    assign half = 8'h01 << r.cfgb[7:5];
    assign tick = run && r.div == 8'(half - 8'h01);
    assign rise = tick && !r.tck;
    assign fall = tick && r.tck;
    assign step_goal = eff_work ? end_st : (busy ? r.goal : r.tap);
    assign host_dout = r.dout;
    assign host_doe = r.doe;
    assign tap_pins = r.po;

    always_comb begin
        n = r;
        oq_push = 1'h0;
        oq_pop = 1'h0;
        iq_push = 1'h0;
        iq_pop = 1'h0;
        iq_wdata = 8'(r.in_sh >> (4'h8 - r.in_cnt));
        flush = 1'h0;
        software_full_reset_bit = 1'h0;
        n.host_s1 = host;
        n.host_s2 = r.host_s1;
        n.tdi_s1 = tdi;
        n.tdi_s2 = r.tdi_s1;
        if (r.host_s2.strb_n) n.acc_done = 1'h0;

        // Host access, performed once per strobe when not blocked
        if (acc && !blocked) begin
            n.acc_done = 1'h1;
            if (a != `JTM_A_CNT) begin
                n.wptr = 2'h0;
                n.rptr = 2'h0;
            end
            if (rd) begin
                unique case (a)
                    `JTM_A_STATUS: n.dout = {!iq_empty, !oq_full, r.cnt_ld,
                        1'h0, r.tap};
                    `JTM_A_CMD: n.dout = r.cmd;
                    `JTM_A_CFGA: n.dout = r.cfga;
                    `JTM_A_CFGB: n.dout = r.cfgb;
                    `JTM_A_CNT: begin
                        n.dout = r.cnt[{r.rptr, 3'h0} +: 8];
                        n.rptr = 2'(r.rptr + 2'h1);
                    end
                    `JTM_A_OUTQ: n.dout = 8'h00;
                    `JTM_A_INQ: begin
                        n.dout = iq_rdata;
                        iq_pop = 1'h1;
                    end
                    `JTM_A_PIN: begin
                        n.dout = r.pin;
                        n.dout[`JTM_PIN_TDI] = r.tdi_s2;
                        if (disc) n.tck = 1'h1;
                    end
                endcase
            end else begin
                unique case (a)
                    `JTM_A_STATUS: begin
                    end
                    `JTM_A_CMD: begin
                        if (wd[`JTM_CMD_SOFTWARE_FULL_RESET_BIT]) begin
                            software_full_reset_bit = 1'h1;
                        end else if (!disc) begin
                            n.cmd = wd;
                            flush = 1'h1;
                            n.out_cnt = 4'h0;
                            n.in_cnt = 4'h0;
                            n.goal = nop.work;
                            if (nop.addressed_scan_port) begin
                                n.fsm = FSM_WORK;
                            end else if (wd[3:0] == `JTM_OP_MOVE) begin
                                n.fsm = FSM_FINISH;
                                n.goal = end_dec(wd[5:4]);
                            end else if (wd[3:0] == `JTM_OP_JUMP) begin
                                n.tap = end_dec(wd[5:4]);
                                n.cmd[3:0] = `JTM_OP_NULL;
                            end else if (wd[3:0] == `JTM_OP_RUN || wd[3]) begin
                                n.fsm = FSM_SEEK;
                            end else begin
                                n.cmd[3:0] = `JTM_OP_NULL;
                            end
                        end
                    end
                    `JTM_A_CFGA: if (!busy) n.cfga = wd;
                    `JTM_A_CFGB: if (!busy) n.cfgb = wd;
                    `JTM_A_CNT: if (!busy) begin
                        if (r.wptr == 2'h0) n.cnt_ld = 1'h0;
                        n.cnt[{r.wptr, 3'h0} +: 8] = wd;
                        n.wptr = 2'(r.wptr + 2'h1);
                        if (r.wptr == 2'h3) n.cnt_ld = 1'h1;
                    end
                    `JTM_A_OUTQ: oq_push = 1'h1;
                    `JTM_A_INQ: begin
                    end
                    `JTM_A_PIN: begin
                        n.pin = wd;
                        if (disc) n.tck = 1'h0;
                    end
                endcase
            end
        end

        // TCK generator, not used in discrete mode
        if (run) begin
            n.div = tick ? 8'h00 : 8'(r.div + 8'h01);
            if (tick) n.tck = !r.tck;
        end else if (!disc) begin
            n.div = 8'h00;
        end

        // Working phase ends once the count is used up
        if (eff_work) begin
            n.fsm = FSM_WORK;
            if (r.cnt == 32'h0) begin
                n.fsm = FSM_FINISH;
                n.goal = op.addressed_scan_port ? r.tap : end_st;
            end
        end
        if (r.fsm == FSM_FINISH && r.tap == r.goal && r.in_cnt == 4'h0) begin
            n.fsm = FSM_IDLE;
            n.cmd[3:0] = `JTM_OP_NULL;
        end

        // Rising TCK: targets advance and sample; counted bit or cycle
        if (rise) begin
            if (!(busy && op.addressed_scan_port)) n.tap = step_nxt;
            if (at_work && r.cnt != 32'h0) begin
                n.cnt = 32'(r.cnt - 32'h1);
                n.last_tdi = r.tdi_s2;
                if (op.uses_in) begin
                    n.in_sh = {r.tdi_s2, r.in_sh[7:1]};
                    n.in_cnt = 4'(r.in_cnt + 4'h1);
                end
            end
        end

        // Falling TCK: new TMS and TDO for the next rising edge
        if (fall) begin
            if (!op.addressed_scan_port) begin
                if (eff_work) begin
                    n.tms = r.cnt <= 32'h1 ? step_toward : 1'h0;
                end else begin
                    n.tms = step_toward;
                end
            end
            if (at_work && op.scan) begin
                if (op.uses_out) begin
                    n.tdo = r.out_sh[0];
                    n.out_sh = {1'h0, r.out_sh[7:1]};
                    n.out_cnt = 4'(r.out_cnt - 4'h1);
                end else begin
                    n.tdo = op.recirc ? r.last_tdi : 1'h1;
                end
            end
        end

        // Buffer service between shift register and FIFOs
        if (busy && op.uses_out && r.out_cnt == 4'h0 && !oq_empty) begin
            oq_pop = 1'h1;
            n.out_sh = oq_rdata;
            n.out_cnt = 4'h8;
        end
        if (!iq_full && (r.in_cnt == 4'h8
            || (r.fsm == FSM_FINISH && r.in_cnt != 4'h0))) begin
            iq_push = 1'h1;
            n.in_cnt = 4'h0;
        end

        // Full reset keeps the strobe synchroniser so it is taken once
        if (software_full_reset_bit) begin
            n = rst_val();
            n.host_s1 = host;
            n.host_s2 = r.host_s1;
            n.acc_done = 1'h1;
            flush = 1'h1;
        end

        n.doe = !r.host_s2.strb_n && r.host_s2.rw;
        n.po.tck = n.tck;
        n.po.tms = disc ? n.pin[`JTM_PIN_TMS] : n.tms;
        n.po.tdo = disc ? n.pin[`JTM_PIN_TDO] : n.tdo;
        n.po.trst_n = disc ? n.pin[`JTM_PIN_TRST]
            : !n.cmd[`JTM_CMD_TRST];
    end

    always_ff @(posedge clock) begin
        if (!nrst) r <= rst_val();
        else if (ce) r <= n;
    end
endmodule

// ===== hw/jtm_fifo.sv
// Four-byte FIFO for scan data, with flush
// Ignores a push when full and a pop when empty
`timescale 1ns/1ns
module jtm_fifo
    import jtm_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input wire logic flush,
    input wire logic push,
    input wire logic [7:0] wdata,
    input wire logic pop,
    output logic [7:0] rdata,
    output logic full,
    output logic empty
);
    jtm_fifo_st_t r, n;
    logic do_push, do_pop;

    assign full = r.cnt == 3'h4;
    assign empty = r.cnt == 3'h0;
    assign rdata = r.mem[r.rp];
    assign do_push = push && !full;
    assign do_pop = pop && !empty;

    always_comb begin
        n = r;
        if (do_push) begin
            n.mem[r.wp] = wdata;
            n.wp = 2'(r.wp + 2'h1);
        end
        if (do_pop) n.rp = 2'(r.rp + 2'h1);
        n.cnt = 3'(r.cnt + {2'h0, do_push} - {2'h0, do_pop});
        if (flush) n = '0;
    end

    always_ff @(posedge clock) begin
        if (!nrst) r <= '0;
        else if (ce) r <= n;
    end
endmodule

// ===== hw/jtm_tap_step.sv
// Target TAP controller model: next state and TMS bit toward a goal
// Purely combinational; the caller holds the current state
`timescale 1ns/1ns
module jtm_tap_step
    import jtm_pkg::*;
(
    input jtm_tap_t cur,
    input jtm_tap_t goal,
    input wire logic tms,
    output logic toward,
    output jtm_tap_t nxt
);
    function automatic logic in_dr(input jtm_tap_t s);
        return s inside {[TAP_CAPDR:TAP_UPDDR]};
    endfunction

    function automatic logic in_ir(input jtm_tap_t s);
        return s inside {[TAP_CAPIR:TAP_UPDIR]};
    endfunction

    always_comb begin
        unique case (cur)
            TAP_TLR: toward = goal == TAP_TLR;
            TAP_RTI: toward = goal != TAP_RTI;
            TAP_SELDR: toward = !in_dr(goal);
            TAP_SELIR: toward = !in_ir(goal);
            TAP_CAPDR, TAP_EX2DR: toward = goal != TAP_SHDR;
            TAP_CAPIR, TAP_EX2IR: toward = goal != TAP_SHIR;
            TAP_SHDR, TAP_SHIR, TAP_PAUSEDR, TAP_PAUSEIR: toward = goal != cur;
            TAP_EX1DR: toward = goal != TAP_PAUSEDR;
            TAP_EX1IR: toward = goal != TAP_PAUSEIR;
            TAP_UPDDR, TAP_UPDIR: toward = goal != TAP_RTI;
        endcase
    end

    always_comb begin
        unique case (cur)
            TAP_TLR: nxt = tms ? TAP_TLR : TAP_RTI;
            TAP_RTI: nxt = tms ? TAP_SELDR : TAP_RTI;
            TAP_SELDR: nxt = tms ? TAP_SELIR : TAP_CAPDR;
            TAP_CAPDR, TAP_SHDR: nxt = tms ? TAP_EX1DR : TAP_SHDR;
            TAP_EX1DR, TAP_EX2DR: nxt = tms ? TAP_UPDDR : TAP_PAUSEDR;
            TAP_PAUSEDR: nxt = tms ? TAP_EX2DR : TAP_PAUSEDR;
            TAP_UPDDR, TAP_UPDIR: nxt = tms ? TAP_SELDR : TAP_RTI;
            TAP_SELIR: nxt = tms ? TAP_TLR : TAP_CAPIR;
            TAP_CAPIR, TAP_SHIR: nxt = tms ? TAP_EX1IR : TAP_SHIR;
            TAP_EX1IR, TAP_EX2IR: nxt = tms ? TAP_UPDIR : TAP_PAUSEIR;
            TAP_PAUSEIR: nxt = tms ? TAP_EX2IR : TAP_PAUSEIR;
        endcase
        if (cur == TAP_EX2DR && !tms) nxt = TAP_SHDR;
        if (cur == TAP_EX2IR && !tms) nxt = TAP_SHIR;
    end
endmodule

// ===== pkg/jtm_pkg.sv
// Types shared by the TAP master core and its leaf modules
// Assumes nothing beyond a SystemVerilog compiler
package jtm_pkg;
    typedef enum logic [3:0] {
        TAP_TLR = 4'h0, TAP_RTI = 4'h1, TAP_SELDR = 4'h2, TAP_CAPDR = 4'h3,
        TAP_SHDR = 4'h4, TAP_EX1DR = 4'h5, TAP_PAUSEDR = 4'h6,
        TAP_EX2DR = 4'h7, TAP_UPDDR = 4'h8, TAP_SELIR = 4'h9,
        TAP_CAPIR = 4'hA, TAP_SHIR = 4'hB, TAP_EX1IR = 4'hC,
        TAP_PAUSEIR = 4'hD, TAP_EX2IR = 4'hE, TAP_UPDIR = 4'hF
    } jtm_tap_t;
    typedef enum logic [3:0] {
        FSM_IDLE = 4'h1, FSM_SEEK = 4'h2, FSM_WORK = 4'h4, FSM_FINISH = 4'h8
    } jtm_fsm_t;
    typedef struct packed {
        logic strb_n;
        logic rw;
        logic [2:0] addr;
        logic [7:0] data;
    } jtm_host_t;
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdo;
        logic trst_n;
    } jtm_tap_pins_t;
    typedef struct packed {
        logic uses_in;
        logic uses_out;
        logic recirc;
        logic addressed_scan_port;
        logic scan;
        jtm_tap_t work;
    } jtm_op_t;
    typedef struct packed {
        logic [3:0][7:0] mem;
        logic [1:0] wp;
        logic [1:0] rp;
        logic [2:0] cnt;
    } jtm_fifo_st_t;
    typedef struct packed {
        jtm_host_t host_s1;
        jtm_host_t host_s2;
        logic tdi_s1;
        logic tdi_s2;
        logic acc_done;
        logic [7:0] dout;
        logic doe;
        logic [7:0] cmd;
        logic [7:0] cfga;
        logic [7:0] cfgb;
        logic [7:0] pin;
        logic [31:0] cnt;
        logic cnt_ld;
        logic [1:0] wptr;
        logic [1:0] rptr;
        jtm_fsm_t fsm;
        jtm_tap_t tap;
        jtm_tap_t goal;
        logic [7:0] div;
        logic tck;
        logic tms;
        logic tdo;
        logic [7:0] out_sh;
        logic [3:0] out_cnt;
        logic [7:0] in_sh;
        logic [3:0] in_cnt;
        logic last_tdi;
        jtm_tap_pins_t po;
    } jtm_core_t;
endpackage

// ===== pkg/jtm_regs.svh
// Register map, field positions and reset values of the TAP master core
// Assumes a 3-bit host address bus and 8-bit host data
`ifndef JTM_REGS_SVH
`define JTM_REGS_SVH
`define JTM_A_STATUS 3'h0
`define JTM_A_CMD 3'h1
`define JTM_A_CFGA 3'h2
`define JTM_A_CFGB 3'h3
`define JTM_A_CNT 3'h4
`define JTM_A_OUTQ 3'h5
`define JTM_A_INQ 3'h6
`define JTM_A_PIN 3'h7
`define JTM_CMD_SOFTWARE_FULL_RESET_BIT 7
`define JTM_CMD_TRST 6
`define JTM_PIN_TDO 0
`define JTM_PIN_TDI 1
`define JTM_PIN_TMS 2
`define JTM_PIN_TRST 3
`define JTM_CFGB_GATED 4
`define JTM_MODE_DISCRETE 3'h0
`define JTM_CFGA_RST 8'h01
`define JTM_CFGB_RST 8'h80
`define JTM_PIN_RST 8'h0D
`define JTM_OP_NULL 4'h0
`define JTM_OP_RUN 4'h2
`define JTM_OP_MOVE 4'h6
`define JTM_OP_JUMP 4'h7
`endif

// ===== verification/jtm_core_properties.sv
// Port-level assertions for the TAP master core
// Assumes a host that holds each strobe until its access completes
`timescale 1ns/1ns
module jtm_core_properties
    import jtm_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input jtm_host_t host,
    input wire logic [7:0] host_dout,
    input wire logic host_doe,
    input wire logic rdy,
    input wire logic tdi,
    input jtm_tap_pins_t tap_pins
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    AST_TMS_ON_LOW: assert property (
        $changed(tap_pins.tms) |-> !tap_pins.tck)
        else $error("TMS changed while TCK high");
    AST_TDO_ON_LOW: assert property (
        $changed(tap_pins.tdo) |-> !tap_pins.tck)
        else $error("TDO changed while TCK high");
    AST_DOE_RISE: assert property (
        $rose(host_doe) |-> !host.strb_n && host.rw)
        else $error("bus drive without a read strobe");
    AST_DOE_IDLE: assert property (
        host.strb_n [*5] |=> !host_doe)
        else $error("bus drive after strobe release");
    AST_DOE_HOLD: assert property (
        !host.strb_n && host_doe |=> host_doe)
        else $error("bus drive dropped during strobe");
    AST_RDY_IDLE: assert property (
        host.strb_n [*5] |-> rdy)
        else $error("ready low with no access");
    AST_RDY_WAIT: assert property (
        !rdy |-> !$past(host.strb_n, 2) || !$past(host.strb_n, 3))
        else $error("ready low without a pending strobe");
    AST_DOUT_HOLD: assert property (
        !host_doe && !$past(host_doe) |-> $stable(host_dout))
        else $error("read data changed outside a read");
endmodule
bind jtm_core jtm_core_properties jtm_core_properties_inst (
    .clock(clock), .nrst(nrst), .ce(ce), .host(host),
    .host_dout(host_dout), .host_doe(host_doe), .rdy(rdy),
    .tdi(tdi), .tap_pins(tap_pins));

// ===== verification/jtm_tgt.sv
// Behavioural target TAP chain with one 8-bit shift path
// Assumes TCK, TMS, TDI and TRST come straight from the master pins
`timescale 1ns/1ns
module jtm_tgt
    import jtm_pkg::*;
#(
    parameter logic [7:0] CAP = 8'h01
)
(
    input wire logic tck,
    input wire logic tms,
    input wire logic din,
    input wire logic trst_n,
    output logic dout,
    output jtm_tap_t st,
    output logic [7:0] sr
);
    localparam logic [63:0] T1 = 64'h2FEFCC0287855920;
    localparam logic [63:0] T0 = 64'h1BDDBBA146644311;
    initial begin
        st = TAP_TLR;
        sr = 8'h00;
        dout = 1'b1;
    end
    always @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            st <= TAP_TLR;
        end else begin
            if (st == TAP_SHDR || st == TAP_SHIR) begin
                sr <= {din, sr[7:1]};
            end
            if (st == TAP_CAPDR || st == TAP_CAPIR) begin
                sr <= CAP;
            end
            st <= jtm_tap_t'(tms ? T1[st*4+:4] : T0[st*4+:4]);
        end
    end
    // Off the shift states the line floats to its pull-up
    always @(negedge tck) begin
        dout <= (st == TAP_SHDR || st == TAP_SHIR) ? sr[0] : 1'b1;
    end
endmodule

// ===== verification/tb_top.sv
// Self-checking bench for the TAP master core and a target chain
// Assumes the register map header and the target model beside it
`timescale 1ns/1ns
`include "jtm_regs.svh"
module tb_top import jtm_pkg::*;;
    logic clock = 0;
    logic nrst = 0;
    logic inv = 1;
    jtm_host_t host = '{1'b1, 1'b1, 3'h0, 8'h00};
    logic [7:0] host_dout, sr, q;
    logic host_doe, rdy, tdi, tdo_t, blk;
    jtm_tap_pins_t tap_pins;
    jtm_tap_t st;
    jtm_tap_t ends [4] = '{TAP_TLR, TAP_RTI, TAP_PAUSEDR, TAP_PAUSEIR};
    int failures = 0, tests_run = 0, cyc = 0, rti = 0;
    assign tdi = tdo_t ^ inv;
    jtm_core jtm_core_inst (.clock(clock), .nrst(nrst), .ce(1'b1),
        .host(host), .host_dout(host_dout), .host_doe(host_doe),
        .rdy(rdy), .tdi(tdi), .tap_pins(tap_pins));
    jtm_tgt jtm_tgt_inst (.tck(tap_pins.tck), .tms(tap_pins.tms),
        .din(tap_pins.tdo), .trst_n(tap_pins.trst_n), .dout(tdo_t),
        .st(st), .sr(sr));
    initial begin
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 40000) begin
            failures++;
            end_of_test();
        end
    end
    always @(posedge tap_pins.tck) begin
        if (st == TAP_RTI) rti++;
    end
    task automatic end_of_test();
        if (failures == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clock);
            #1;
        end
    endtask
    task automatic chk(input string s, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", s, e, g);
        end
    endtask
    // Strobe is held until ready, or released early after lim cycles
    task automatic acc(input logic r, input logic [2:0] a,
                       input logic [7:0] d, input int lim);
        int n;
        n = 0;
        blk = 0;
        host.rw = r;
        host.addr = a;
        host.data = d;
        host.strb_n = 0;
        tick(4);
        while (rdy !== 1'b1 && n < lim) begin
            blk = 1;
            n++;
            tick(1);
        end
        tick(2);
        q = host_dout;
        host.strb_n = 1;
        tick(4);
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        acc(1'b0, a, d, 3000);
    endtask
    task automatic rd(input logic [2:0] a);
        acc(1'b1, a, 8'h00, 3000);
    endtask
    task automatic ld(input logic [31:0] v, input int n);
        for (int i = 0; i < n; i++) wr(`JTM_A_CNT, v[i*8+:8]);
    endtask
    task automatic done();
        for (int i = 0; i < 300; i++) begin
            rd(`JTM_A_CMD);
            if (q[3:0] === 4'h0) break;
        end
        chk("opcode", 0, q[3:0]);
    endtask
    task automatic go(input logic [7:0] c, input jtm_tap_t e);
        wr(`JTM_A_CMD, c);
        done();
        rd(`JTM_A_STATUS);
        chk("tap_state", e, q[3:0]);
        chk("target_state", e, st);
    endtask
    task automatic t_regs();
        rd(`JTM_A_PIN);
        chk("pin_reset", 8'h0D, q);
        ld(32'hFFFFFFFF, 4);
        ld(32'h00000000, 3);
        rd(`JTM_A_STATUS);
        chk("loaded_part", 0, q[5]);
        ld(32'h11223344, 4);
        rd(`JTM_A_STATUS);
        chk("loaded_full", 1, q[5]);
        for (int i = 0; i < 4; i++) begin
            rd(`JTM_A_CNT);
            chk("cnt_byte", 8'h44 - 8'h11 * i, q);
        end
        rd(`JTM_A_STATUS);
        chk("loaded_read", 1, q[5]);
    endtask
    task automatic t_discrete();
        logic [7:0] v;
        wr(`JTM_A_CFGA, 8'h00);
        for (int i = 0; i < 2; i++) begin
            v = i ? 8'h05 : 8'h08;
            inv = i[0];
            wr(`JTM_A_PIN, v);
            chk("tck_write", 0, tap_pins.tck);
            chk("pins", {v[3], v[2], v[0]},
                {tap_pins.trst_n, tap_pins.tms, tap_pins.tdo});
            rd(`JTM_A_PIN);
            chk("tck_read", 1, tap_pins.tck);
            chk("tdi_bit", i == 0, q[1]);
        end
        wr(`JTM_A_CMD, 8'h12);
        rd(`JTM_A_CMD);
        chk("cmd_discrete", 0, q[3:0]);
        inv = 0;
        wr(`JTM_A_CFGA, 8'h01);
        wr(`JTM_A_PIN, 8'h00);
        chk("trst_auto", 1, tap_pins.trst_n);
        rd(`JTM_A_PIN);
        chk("pin_auto", 8'h02, q);
        for (int i = 1; i < 5; i++) begin
            go({2'b00, 2'(i), 4'h6}, ends[i % 4]);
        end
    endtask
    task automatic t_jump();
        // Gated TCK so the idle hold level cannot walk the parked target
        wr(`JTM_A_CFGB, 8'h90);
        go(8'h26, TAP_PAUSEDR);
        wr(`JTM_A_CMD, 8'h07);
        done();
        rd(`JTM_A_STATUS);
        chk("jump_state", TAP_TLR, q[3:0]);
        chk("jump_target", TAP_PAUSEDR, st);
        wr(`JTM_A_CMD, 8'h27);
        go(8'h16, TAP_RTI);
    endtask
    task automatic t_run();
        int r;
        wr(`JTM_A_CFGB, 8'h90);
        ld(32'd20, 4);
        rti = 0;
        wr(`JTM_A_CMD, 8'h12);
        ld(32'd3, 4);
        wr(`JTM_A_CFGB, 8'h80);
        wr(`JTM_A_CMD, 8'h16);
        r = rti;
        chk("cmd_blocked", 1, blk);
        chk("run_length", 1, r >= 20 && r <= 21);
        done();
        rd(`JTM_A_CFGB);
        chk("cfg_frozen", 8'h90, q);
    endtask
    task automatic t_scan();
        acc(1'b1, `JTM_A_INQ, 8'h00, 20);
        chk("inq_empty", 1, blk);
        for (int i = 0; i < 4; i++) wr(`JTM_A_OUTQ, 8'h11);
        rd(`JTM_A_STATUS);
        chk("outq_full", 0, q[6]);
        acc(1'b0, `JTM_A_OUTQ, 8'h22, 20);
        chk("outq_block", 1, blk);
        ld(32'd8, 4);
        wr(`JTM_A_CMD, 8'h18);
        wr(`JTM_A_OUTQ, 8'h5A);
        rd(`JTM_A_INQ);
        chk("scan_in", 8'h01, q);
        done();
        chk("scan_out", 8'h5A, sr);
        wr(`JTM_A_CFGB, 8'h90);
        for (int op = 0; op < 16; op++) begin
            ld(32'd1, 4);
            wr(`JTM_A_CMD, {4'h1, 4'(op)});
            wr(`JTM_A_OUTQ, 8'h00);
            go(8'h10, TAP_RTI);
        end
    endtask
    initial begin
        repeat (8) @(posedge clock);
        #1;
        nrst = 1;
        tick(3);
        t_regs();
        t_discrete();
        t_jump();
        t_run();
        t_scan();
        end_of_test();
    end
endmodule
